// >>> hw/rtc_pkg.sv
// Constants and types shared by the RTC value block
package rtc_pkg;
   // Register selects on the special function port
   localparam logic [2:0] SEL_CFG = 3'h0;
   localparam logic [2:0] SEL_PWC = 3'h1;
   localparam logic [2:0] SEL_ALPTR = 3'h2;
   localparam logic [2:0] SEL_VAL = 3'h3;
   localparam logic [2:0] SEL_ALVAL = 3'h4;
   // Window pointer values
   localparam logic [1:0] PTR_YEAR = 2'h3;
   localparam logic [1:0] PTR_MONTH_DAY_VALUE = 2'h2;
   localparam logic [1:0] PTR_WKHR = 2'h1;
   localparam logic [1:0] PTR_MINUTE_SECOND_VALUE = 2'h0;
   localparam logic [1:0] PTR_PWCWIN = 2'h3;
   // Implemented bits per window register
   localparam logic [15:0] MASK_YEAR = 16'h00ff;
   localparam logic [15:0] MASK_MONTH_DAY_VALUE = 16'h1f3f;
   localparam logic [15:0] MASK_WKHR = 16'h073f;
   localparam logic [15:0] MASK_MINUTE_SECOND_VALUE = 16'h7f7f;
   localparam logic [15:0] MASK_PWCWIN = 16'hffff;
   // Calibration and configuration bit positions
   localparam int CFG_EN_BIT = 15;
   localparam int CFG_WREN_BIT = 13;
   localparam int CFG_SYNC_BIT = 12;
   localparam int CFG_HALF_BIT = 11;
   localparam int CFG_PTR_LSB = 8;
   localparam int PWC_EN_BIT = 15;
   localparam int ALPTR_LSB = 8;
   // Reset values
   localparam logic [15:0] VAL_RESET = 16'h0000;
   localparam logic [7:0] CAL_RESET = 8'h00;
   // Prescaler: one second is 32768 reference ticks, offset for headroom
   localparam logic [15:0] PRE_BASE = 16'h0080;
   localparam logic [15:0] PRE_TOP = 16'h807f;
   localparam logic [15:0] PRE_HALF = 16'h4080;
   localparam logic [15:0] SYNC_LEAD = 16'h0020;
   // Calendar digit limits
   localparam logic [3:0] BCD_NINE = 4'h9;
   localparam logic [3:0] TENS_FIVE = 4'h5;
   localparam logic [3:0] WEEKDAY_DIGIT_MAX = 4'h6;
   localparam logic [5:0] HOUR_LAST = 6'h23;
   localparam logic [5:0] DAY_FIRST = 6'h01;
   localparam logic [4:0] MONTH_LAST = 5'h12;
   localparam logic [4:0] MONTH_FIRST = 5'h01;
   localparam logic [7:0] SAMP_ALWAYS = 8'hff;
   typedef enum logic [2:0] {
      PWC_IDLE = 3'b001,
      PWC_STAB = 3'b010,
      PWC_SAMP = 3'b100
   } rtc_pwc_state_e;
endpackage : rtc_pkg

// >>> hw/rtc_pwc_if.sv
// Power control window signals between the value block and its timer
`timescale 1ns/1ps
interface rtc_pwc_if;
   logic pwc_en;
   logic alarm_event;
   logic pwc_tick;
   logic [7:0] stab_count;
   logic [7:0] samp_count;
   logic stab_win;
   logic samp_win;
   modport ctl (output pwc_en, alarm_event, pwc_tick, stab_count,
      samp_count, input stab_win, samp_win);
   modport win (input pwc_en, alarm_event, pwc_tick, stab_count,
      samp_count, output stab_win, samp_win);
endinterface : rtc_pwc_if

// >>> hw/rtc_pwc_win.sv
// Stability and sample window timer for power control
`timescale 1ns/1ps
module rtc_pwc_win
   import rtc_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   rtc_pwc_if.win pw
);
   rtc_pwc_state_e state_ff, nxt_state;
   logic [7:0] cnt_ff, nxt_cnt;
   logic stab_ff, nxt_stab;
   logic samp_ff, nxt_samp;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      case (state_ff)
         PWC_IDLE: begin
            if (pw.pwc_en && pw.alarm_event) begin
               if (pw.stab_count != 8'h00) begin
                  nxt_state = PWC_STAB;
                  nxt_cnt = pw.stab_count;
               end else if (pw.samp_count != 8'h00) begin
                  nxt_state = PWC_SAMP;
                  nxt_cnt = pw.samp_count;
               end
            end
         end
         PWC_STAB: begin
            if (pw.pwc_tick) begin
               if (cnt_ff == 8'h01) begin
                  nxt_cnt = pw.samp_count;
                  nxt_state = (pw.samp_count == 8'h00) ? PWC_IDLE : PWC_SAMP;
               end else begin
                  nxt_cnt = cnt_ff - 8'h01;
               end
            end
         end
         PWC_SAMP: begin
            if (pw.pwc_tick) begin
               if (cnt_ff == 8'h01) begin
                  nxt_state = PWC_IDLE;
               end else begin
                  nxt_cnt = cnt_ff - 8'h01;
               end
            end
         end
         default: nxt_state = PWC_IDLE;
      endcase
      if (!pw.pwc_en) begin
         nxt_state = PWC_IDLE;
      end
      nxt_stab = (nxt_state == PWC_STAB);
      nxt_samp = (nxt_state == PWC_SAMP)
         || (pw.samp_count == SAMP_ALWAYS);
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= PWC_IDLE;
         cnt_ff <= 8'h00;
         stab_ff <= 1'b0;
         samp_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         stab_ff <= nxt_stab;
         samp_ff <= nxt_samp;
      end
   end

   assign pw.stab_win = stab_ff;
   assign pw.samp_win = samp_ff;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   property p_stab_start;
      (state_ff == PWC_IDLE) && pw.pwc_en && pw.alarm_event
         && (pw.stab_count != 8'h00) |=> stab_ff && !state_ff[0];
   endproperty
   a_stab_start: assert property (p_stab_start)
      else $error("stability window did not open on alarm");

   property p_samp_always;
      pw.samp_count == SAMP_ALWAYS |=> samp_ff;
   endproperty
   a_samp_always: assert property (p_samp_always)
      else $error("sample window not held open for all ones");

   property p_no_stab_direct;
      (state_ff == PWC_IDLE) && pw.pwc_en && pw.alarm_event
         && (pw.stab_count == 8'h00) && (pw.samp_count != 8'h00)
         |=> samp_ff && !stab_ff;
   endproperty
   a_no_stab_direct: assert property (p_no_stab_direct)
      else $error("sample window did not start at alarm");

   property p_samp_zero;
      (state_ff == PWC_IDLE) && pw.alarm_event && (pw.stab_count == 8'h00)
         && (pw.samp_count == 8'h00) |=> !samp_ff;
   endproperty
   a_samp_zero: assert property (p_samp_zero)
      else $error("sample window opened for zero count");

   c_samp_window: cover property (stab_ff ##1 !stab_ff && samp_ff);
endmodule : rtc_pwc_win

// >>> hw/rtc_value_core.sv
// Calendar values, alarm values, windows and drift calibration
// Operation
// - Year holds BCD tens in bits 7-4 and ones in 3-0, 0 to 9
// - Month tens is bit 12, month ones BCD in bits 11-8
// - Day tens in bits 5-4 (0 to 3), ones in bits 3-0
// - Weekday sits in bits 10-8 and runs 0 to 6
// - Hour tens in bits 5-4 (0 to 2), ones in bits 3-0
// - Minute tens in bits 14-12 (0 to 5), ones in 11-8
// - Second tens in bits 6-4 (0 to 5), ones in 3-0
// - Unassigned bits of value registers read zero, ignore writes
// - Value and window registers write only while write enable set, except minute/second, which always writes
// - Alarm registers 0 to 2 share the value registers' field layout, alarm register 3 holds the windows
// - Stability window lasts N power clock periods, zero means none
// - Sample window lasts N periods for 1 to 254, zero means none
// - Sample count all ones keeps sample window always active
// - Sample window follows stability expiry, or alarm when stability zero
// - Signed drift byte times four pulses adjusts timer each minute
// - Drift adjust happens at every fifteen-second boundary
// - Pointer picks register, decrements on upper byte access to zero
// - Writing minute/second low byte clears the half-second flag
`timescale 1ns/1ps
module rtc_value_core
   import rtc_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic rtc_tick,
   input wire logic pwc_tick,
   input wire logic alarm_event,
   input wire logic [2:0] reg_sel,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [1:0] reg_be,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic second_pulse,
   output logic half_second,
   output logic stab_window,
   output logic samp_window
);
   logic [15:0] val_ff [4];
   logic [15:0] nxt_val [4];
   logic [15:0] alm_ff [4];
   logic [15:0] nxt_alm [4];
   logic [1:0] ptr_ff, nxt_ptr;
   logic [1:0] alptr_ff, nxt_alptr;
   logic en_ff, nxt_en;
   logic wren_ff, nxt_wren;
   logic [7:0] cal_ff, nxt_cal;
   logic pwc_en_ff, nxt_pwc_en;
   logic [15:0] pre_ff, nxt_pre;
   logic [15:0] rdata_ff, nxt_rdata;
   logic sec_ff, nxt_sec;
   logic half_ff, nxt_half;
   logic sec_tick;
   logic cal_point;
   logic wr_minute_second_value_lo;
   logic [15:0] byte_mask;

   rtc_pwc_if pw ();

   function automatic logic [4:0] bcd_step(input logic [3:0] d,
      input logic [3:0] top);
      bcd_step = (d >= top) ? 5'h10 : {1'b0, d + 4'h1};
   endfunction : bcd_step

   assign sec_tick = rtc_tick && en_ff && (pre_ff == PRE_TOP);
   assign byte_mask = {{8{reg_be[1]}}, {8{reg_be[0]}}};
   assign wr_minute_second_value_lo = reg_wr && (reg_sel == SEL_VAL) && reg_be[0]
      && (ptr_ff == PTR_MINUTE_SECOND_VALUE);

   ////////////////////////////////////////////////////////////////////////
   // Calendar cascade, prescaler and register access
   always_comb begin
      logic [15:0] ms;
      logic [15:0] wh;
      logic [15:0] md;
      logic [15:0] yr;
      logic [4:0] st;
      logic day_carry;
      logic leap;
      logic [5:0] dim;
      logic [15:0] wmask;
      ms = val_ff[0];
      wh = val_ff[1];
      md = val_ff[2];
      yr = val_ff[3];
      st = 5'h00;
      day_carry = 1'b0;
      leap = 1'b0;
      dim = 6'h31;
      wmask = 16'h0000;
      nxt_alm = alm_ff;
      nxt_ptr = ptr_ff;
      nxt_alptr = alptr_ff;
      nxt_en = en_ff;
      nxt_wren = wren_ff;
      nxt_cal = cal_ff;
      nxt_pwc_en = pwc_en_ff;
      nxt_rdata = rdata_ff;
      nxt_pre = pre_ff;
      cal_point = 1'b0;
      if (sec_tick) begin
         st = bcd_step(ms[3:0], BCD_NINE);
         ms[3:0] = st[3:0];
         if (st[4]) begin
            st = bcd_step({1'b0, ms[6:4]}, TENS_FIVE);
            ms[6:4] = st[2:0];
            if (st[4]) begin
               st = bcd_step(ms[11:8], BCD_NINE);
               ms[11:8] = st[3:0];
               if (st[4]) begin
                  st = bcd_step({1'b0, ms[14:12]}, TENS_FIVE);
                  ms[14:12] = st[2:0];
                  if (st[4]) begin
                     if (wh[5:0] == HOUR_LAST) begin
                        wh[5:0] = 6'h00;
                        day_carry = 1'b1;
                        st = bcd_step({1'b0, wh[10:8]}, WEEKDAY_DIGIT_MAX);
                        wh[10:8] = st[2:0];
                     end else if (wh[3:0] == BCD_NINE) begin
                        wh[3:0] = 4'h0;
                        wh[5:4] = wh[5:4] + 2'h1;
                     end else begin
                        wh[3:0] = wh[3:0] + 4'h1;
                     end
                  end
               end
            end
         end
         leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
            : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
         case (md[12:8])
            5'h02: dim = leap ? 6'h29 : 6'h28;
            5'h04, 5'h06, 5'h09, 5'h11: dim = 6'h30;
            default: dim = 6'h31;
         endcase
         if (day_carry) begin
            if (md[5:0] == dim) begin
               md[5:0] = DAY_FIRST;
               if (md[12:8] == MONTH_LAST) begin
                  md[12:8] = MONTH_FIRST;
                  st = bcd_step(yr[3:0], BCD_NINE);
                  yr[3:0] = st[3:0];
                  if (st[4]) begin
                     st = bcd_step(yr[7:4], BCD_NINE);
                     yr[7:4] = st[3:0];
                  end
               end else if (md[11:8] == BCD_NINE) begin
                  md[12:8] = 5'h10;
               end else begin
                  md[11:8] = md[11:8] + 4'h1;
               end
            end else if (md[3:0] == BCD_NINE) begin
               md[3:0] = 4'h0;
               md[5:4] = md[5:4] + 2'h1;
            end else begin
               md[3:0] = md[3:0] + 4'h1;
            end
         end
         cal_point = (ms[3:0] == 4'h0 || ms[3:0] == 4'h5)
            && (ms[6:4] == 3'h0 || ms[6:4] == 3'h1 || ms[6:4] == 3'h3
            || ms[6:4] == 3'h4) && (ms[7:0] != 8'h10) && (ms[7:0] != 8'h40)
            && (ms[7:0] != 8'h35) && (ms[7:0] != 8'h05);
         if (cal_point) begin
            nxt_pre = PRE_BASE + {{8{cal_ff[7]}}, cal_ff};
         end else begin
            nxt_pre = PRE_BASE;
         end
      end else if (rtc_tick && en_ff) begin
         nxt_pre = pre_ff + 16'h0001;
      end
      nxt_val[0] = ms;
      nxt_val[1] = wh;
      nxt_val[2] = md;
      nxt_val[3] = yr;
      // Register writes win over the calendar update
      if (reg_wr && reg_sel == SEL_CFG) begin
         if (reg_be[1]) begin
            if (wren_ff) begin
               nxt_en = reg_wdata[CFG_EN_BIT];
            end
            nxt_wren = reg_wdata[CFG_WREN_BIT];
            nxt_ptr = reg_wdata[CFG_PTR_LSB+1:CFG_PTR_LSB];
         end
         if (reg_be[0]) begin
            nxt_cal = reg_wdata[7:0];
         end
      end else if (reg_wr && reg_sel == SEL_PWC) begin
         if (reg_be[1]) begin
            nxt_pwc_en = reg_wdata[PWC_EN_BIT];
         end
      end else if (reg_wr && reg_sel == SEL_ALPTR) begin
         if (reg_be[1]) begin
            nxt_alptr = reg_wdata[ALPTR_LSB+1:ALPTR_LSB];
         end
      end else if (reg_wr && reg_sel == SEL_VAL) begin
         case (ptr_ff)
            PTR_YEAR: wmask = MASK_YEAR;
            PTR_MONTH_DAY_VALUE: wmask = MASK_MONTH_DAY_VALUE;
            PTR_WKHR: wmask = MASK_WKHR;
            default: wmask = MASK_MINUTE_SECOND_VALUE;
         endcase
         if (wren_ff || ptr_ff == PTR_MINUTE_SECOND_VALUE) begin
            wmask = wmask & byte_mask;
            nxt_val[ptr_ff] = (nxt_val[ptr_ff] & ~wmask)
               | (reg_wdata & wmask);
         end
         if (wr_minute_second_value_lo) begin
            nxt_pre = PRE_BASE;
         end
      end else if (reg_wr && reg_sel == SEL_ALVAL) begin
         case (alptr_ff)
            PTR_PWCWIN: wmask = MASK_PWCWIN;
            PTR_MONTH_DAY_VALUE: wmask = MASK_MONTH_DAY_VALUE;
            PTR_WKHR: wmask = MASK_WKHR;
            default: wmask = MASK_MINUTE_SECOND_VALUE;
         endcase
         if (wren_ff || alptr_ff == PTR_MINUTE_SECOND_VALUE) begin
            wmask = wmask & byte_mask;
            nxt_alm[alptr_ff] = (alm_ff[alptr_ff] & ~wmask)
               | (reg_wdata & wmask);
         end
      end
      if ((reg_wr || reg_rd) && reg_be[1] && ptr_ff != 2'h0
         && reg_sel == SEL_VAL) begin
         nxt_ptr = ptr_ff - 2'h1;
      end
      if ((reg_wr || reg_rd) && reg_be[1] && alptr_ff != 2'h0
         && reg_sel == SEL_ALVAL) begin
         nxt_alptr = alptr_ff - 2'h1;
      end
      if (reg_rd) begin
         if (reg_sel == SEL_CFG) begin
            nxt_rdata = {en_ff, 1'b0, wren_ff,
               pre_ff >= (PRE_TOP - SYNC_LEAD), half_ff, 1'b0, ptr_ff,
               cal_ff};
         end else if (reg_sel == SEL_PWC) begin
            nxt_rdata = {pwc_en_ff, 15'h0000};
         end else if (reg_sel == SEL_ALPTR) begin
            nxt_rdata = {6'h00, alptr_ff, 8'h00};
         end else if (reg_sel == SEL_VAL) begin
            nxt_rdata = val_ff[ptr_ff];
         end else if (reg_sel == SEL_ALVAL) begin
            nxt_rdata = alm_ff[alptr_ff];
         end else begin
            nxt_rdata = 16'h0000;
         end
      end
      nxt_sec = sec_tick;
      nxt_half = (nxt_pre >= PRE_HALF);
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 4; i++) begin
            val_ff[i] <= VAL_RESET;
            alm_ff[i] <= VAL_RESET;
         end
         ptr_ff <= 2'h0;
         alptr_ff <= 2'h0;
         en_ff <= 1'b0;
         wren_ff <= 1'b0;
         cal_ff <= CAL_RESET;
         pwc_en_ff <= 1'b0;
         pre_ff <= PRE_BASE;
         rdata_ff <= 16'h0000;
         sec_ff <= 1'b0;
         half_ff <= 1'b0;
      end else begin
         val_ff <= nxt_val;
         alm_ff <= nxt_alm;
         ptr_ff <= nxt_ptr;
         alptr_ff <= nxt_alptr;
         en_ff <= nxt_en;
         wren_ff <= nxt_wren;
         cal_ff <= nxt_cal;
         pwc_en_ff <= nxt_pwc_en;
         pre_ff <= nxt_pre;
         rdata_ff <= nxt_rdata;
         sec_ff <= nxt_sec;
         half_ff <= nxt_half;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power control windows
   assign pw.pwc_en = pwc_en_ff;
   assign pw.alarm_event = alarm_event;
   assign pw.pwc_tick = pwc_tick;
   assign pw.stab_count = alm_ff[PTR_PWCWIN][15:8];
   assign pw.samp_count = alm_ff[PTR_PWCWIN][7:0];

   rtc_pwc_win i_rtc_pwc_win (
      .mclk(mclk),
      .rstn(rstn),
      .pw(pw)
   );

   assign reg_rdata = rdata_ff;
   assign second_pulse = sec_ff;
   assign half_second = half_ff;
   assign stab_window = pw.stab_win;
   assign samp_window = pw.samp_win;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   property p_lock;
      reg_wr && reg_sel == SEL_VAL && ptr_ff == PTR_YEAR && !wren_ff
         && !sec_tick |=> val_ff[3] == $past(val_ff[3]);
   endproperty
   a_lock: assert property (p_lock)
      else $error("year written while locked");

   property p_reserved;
      (val_ff[2] & ~MASK_MONTH_DAY_VALUE) == 16'h0000
         && (val_ff[1] & ~MASK_WKHR) == 16'h0000
         && (alm_ff[0] & ~MASK_MINUTE_SECOND_VALUE) == 16'h0000;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("unimplemented value bit set");

   property p_ptr_dec;
      reg_rd && !reg_wr && reg_sel == SEL_VAL && reg_be[1]
         && ptr_ff != 2'h0 |=> ptr_ff == $past(ptr_ff) - 2'h1;
   endproperty
   a_ptr_dec: assert property (p_ptr_dec)
      else $error("window pointer did not decrement");

   property p_ptr_floor;
      (reg_rd || reg_wr) && reg_sel == SEL_VAL && ptr_ff == 2'h0
         |=> ptr_ff == 2'h0;
   endproperty
   a_ptr_floor: assert property (p_ptr_floor)
      else $error("window pointer went below zero");

   property p_half_clear;
      wr_minute_second_value_lo |=> !half_ff ##1 !half_ff;
   endproperty
   a_half_clear: assert property (p_half_clear)
      else $error("half second flag not cleared");

   property p_sec_ones;
      sec_tick && val_ff[0][3:0] < BCD_NINE && !reg_wr
         |=> val_ff[0][3:0] == $past(val_ff[0][3:0]) + 4'h1;
   endproperty
   a_sec_ones: assert property (p_sec_ones)
      else $error("seconds ones digit did not advance");

   property p_cal_adjust;
      sec_tick && cal_point && !wr_minute_second_value_lo
         |=> pre_ff == PRE_BASE + {{8{$past(cal_ff[7])}}, $past(cal_ff)};
   endproperty
   a_cal_adjust: assert property (p_cal_adjust)
      else $error("drift adjust not applied at boundary");

   property p_min_carry;
      sec_tick && val_ff[0][6:0] == 7'h59 && val_ff[0][11:8] < BCD_NINE
         && !reg_wr |=> val_ff[0][6:0] == 7'h00
         && val_ff[0][11:8] == $past(val_ff[0][11:8]) + 4'h1;
   endproperty
   a_min_carry: assert property (p_min_carry)
      else $error("minute carry missing");

   c_second: cover property (sec_ff && val_ff[0][7:0] == 8'h00);
   c_cal_point: cover property (sec_tick && cal_point && cal_ff != 8'h00);
   c_ptr_walk: cover property (ptr_ff == PTR_YEAR ##[1:8] ptr_ff == 2'h0);
endmodule : rtc_value_core

// >>> verif/tb_rtc_value_core.sv
// Self-checking bench for the RTC value block
`timescale 1ns/1ps
module tb_rtc_value_core
   import rtc_pkg::*;
;
   logic mclk, rstn, rtc_tick, pwc_tick, alarm_event, reg_wr, reg_rd;
   logic [2:0] reg_sel;
   logic [1:0] reg_be;
   logic [15:0] reg_wdata, reg_rdata;
   logic second_pulse, half_second, stab_window, samp_window;
   logic [15:0] masks [4];
   int fails, checked, n;

   rtc_value_core i_rtc_value_core (.mclk(mclk), .rstn(rstn),
      .rtc_tick(rtc_tick), .pwc_tick(pwc_tick),
      .alarm_event(alarm_event), .reg_sel(reg_sel), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .second_pulse(second_pulse),
      .half_second(half_second), .stab_window(stab_window),
      .samp_window(samp_window));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [2:0] s, input logic [1:0] b,
      input logic [15:0] d);
      @(negedge mclk);
      reg_sel = s;
      reg_be = b;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] s, input logic [1:0] b,
      input string w, input logic [15:0] e);
      @(negedge mclk);
      reg_sel = s;
      reg_be = b;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      chk(w, e, reg_rdata);
   endtask : rd

   task automatic win(input logic s, input logic p);
      chk("stab_window", {15'h0, s}, {15'h0, stab_window});
      chk("samp_window", {15'h0, p}, {15'h0, samp_window});
   endtask : win

   task automatic ptick(input int k);
      repeat (k) begin
         @(negedge mclk);
         pwc_tick = 1'b1;
         @(negedge mclk);
         pwc_tick = 1'b0;
      end
      repeat (2) @(negedge mclk);
   endtask : ptick

   task automatic alarm();
      @(negedge mclk);
      alarm_event = 1'b1;
      @(negedge mclk);
      alarm_event = 1'b0;
   endtask : alarm

   // Counts negedges up to the next second pulse
   task automatic wait_sec();
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (second_pulse !== 1'b1 && n < 40000);
   endtask : wait_sec

   task automatic report_and_stop();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////////////
   // Two seconds, half a second and register traffic fit well inside
   initial begin
      repeat (95000) @(posedge mclk);
      fails++;
      report_and_stop();
   end

   initial begin
      {rtc_tick, pwc_tick, alarm_event, reg_wr, reg_rd} = 5'h00;
      reg_sel = 3'h0;
      reg_be = 2'h0;
      reg_wdata = 16'h0000;
      fails = 0;
      checked = 0;
      rstn = 1'b0;
      repeat (6) @(negedge mclk);
      rstn = 1'b1;
      rd(SEL_CFG, 2'h3, "cfg", 16'h0000);
      rd(3'h5, 2'h3, "unmapped", 16'h0000);
      // Point at the year while still locked, then try to write it
      wr(SEL_CFG, 2'h3, 16'h0300);
      wr(SEL_VAL, 2'h3, 16'hffff);
      wr(SEL_CFG, 2'h3, 16'h2300);
      rd(SEL_VAL, 2'h3, "locked year", 16'h0000);
      masks = '{MASK_YEAR, MASK_MONTH_DAY_VALUE, MASK_WKHR, MASK_MINUTE_SECOND_VALUE};
      wr(SEL_CFG, 2'h3, 16'h2300);
      for (int i = 0; i < 4; i++) wr(SEL_VAL, 2'h3, 16'hffff);
      wr(SEL_CFG, 2'h3, 16'h2300);
      for (int i = 0; i < 4; i++) begin
         rd(SEL_VAL, 2'h3, "mask", masks[i]);
      end
      wr(SEL_CFG, 2'h3, 16'h2100);
      rd(SEL_VAL, 2'h1, "low lane", MASK_WKHR);
      rd(SEL_VAL, 2'h3, "no step", MASK_WKHR);
      rd(SEL_VAL, 2'h3, "step", MASK_MINUTE_SECOND_VALUE);
      rd(SEL_VAL, 2'h3, "floor", MASK_MINUTE_SECOND_VALUE);
      $display("test value window done");
      masks[0] = MASK_PWCWIN;
      wr(SEL_ALPTR, 2'h3, 16'h0300);
      for (int i = 0; i < 4; i++) wr(SEL_ALVAL, 2'h3, 16'hffff);
      wr(SEL_ALPTR, 2'h3, 16'h0300);
      for (int i = 0; i < 4; i++) begin
         rd(SEL_ALVAL, 2'h3, "alarm mask", masks[i]);
      end
      win(1'b0, 1'b1);
      wr(SEL_ALPTR, 2'h3, 16'h0300);
      wr(SEL_ALVAL, 2'h3, 16'h0302);
      wr(SEL_PWC, 2'h3, 16'h8000);
      alarm();
      win(1'b1, 1'b0);
      ptick(2);
      win(1'b1, 1'b0);
      ptick(1);
      win(1'b0, 1'b1);
      ptick(1);
      win(1'b0, 1'b1);
      ptick(1);
      win(1'b0, 1'b0);
      wr(SEL_ALPTR, 2'h3, 16'h0300);
      wr(SEL_ALVAL, 2'h3, 16'h0001);
      alarm();
      win(1'b0, 1'b1);
      ptick(1);
      win(1'b0, 1'b0);
      wr(SEL_PWC, 2'h3, 16'h0000);
      $display("test power windows done");
      // Positive drift for a slow crystal, loaded while stopped
      wr(SEL_CFG, 2'h3, 16'h2310);
      wr(SEL_VAL, 2'h3, 16'h0099);
      wr(SEL_VAL, 2'h3, 16'h1231);
      wr(SEL_VAL, 2'h3, 16'h0623);
      wr(SEL_VAL, 2'h3, 16'h5959);
      wr(SEL_CFG, 2'h3, 16'ha010);
      rtc_tick = 1'b1;
      wait_sec();
      wait_sec();
      chk("second ticks", 16'd32752, n[15:0]);
      wr(SEL_CFG, 2'h3, 16'ha310);
      rd(SEL_VAL, 2'h3, "year", 16'h0000);
      rd(SEL_VAL, 2'h3, "month day", 16'h0101);
      rd(SEL_VAL, 2'h3, "weekday hour", 16'h0000);
      rd(SEL_VAL, 2'h3, "minute second", 16'h0001);
      $display("test calendar done");
      n = 0;
      while (half_second !== 1'b1 && n < 20000) begin
         @(negedge mclk);
         n++;
      end
      rd(SEL_CFG, 2'h3, "cfg half", 16'ha810);
      wr(SEL_VAL, 2'h1, 16'h0030);
      chk("half_second", 16'h0000, {15'h0, half_second});
      rd(SEL_VAL, 2'h3, "second set", 16'h0030);
      $display("test half second done");
      report_and_stop();
   end
endmodule : tb_rtc_value_core
